// file: logic/fenp_pkg.sv
package fenp_pkg;

  // ****************************************************************
  // Code groups
  // ****************************************************************
  localparam logic [4:0] C_I = 5'h1F;
  localparam logic [4:0] C_J = 5'h18;
  localparam logic [4:0] C_K = 5'h11;
  localparam logic [4:0] C_T = 5'h0D;
  localparam logic [4:0] C_R = 5'h07;
  localparam logic [4:0] C_H = 5'h04;

  // Data map, nibble F down to nibble 0
  localparam logic [79:0] ENC_TAB = {
    5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
  // Invalid groups, V9 down to V0
  localparam logic [49:0] VIOL_TAB = {
    5'h19, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01,
    5'h00};

  localparam logic [3:0] NIB_CTL    = 4'h0;
  localparam logic [3:0] NIB_VIOL_N = 4'h5;
  localparam logic [3:0] NIB_VIOL_S = 4'h6;
  localparam logic [3:0] NIB_FALSE  = 4'hE;
  localparam logic [3:0] NIB_V0     = 4'h1;
  localparam logic [3:0] NIB_V1     = 4'h7;
  localparam logic [3:0] NIB_V2     = 4'h8;

  // ****************************************************************
  // Registers, reset values and timing
  // ****************************************************************
  localparam logic [4:0]  ADDR_DROP = 5'h12;
  localparam logic [4:0]  ADDR_FC   = 5'h13;
  localparam logic [15:0] CNT_RST   = 16'h0000;

  localparam int CLK_MHZ       = 100;
  localparam int LINK_UP_MS    = 1;
  localparam int LINK_DOWN_US  = 350;
  localparam int LINK_UP_CYC   = LINK_UP_MS * 1000 * CLK_MHZ;
  localparam int LINK_DOWN_CYC = LINK_DOWN_US * CLK_MHZ;
  localparam logic [3:0] IDLE_RUN = 4'hC;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_J     = 5'h02,
    RX_DATA  = 5'h04,
    RX_END   = 5'h08,
    RX_FALSE = 5'h10
  } fenp_rx_t;

  // ****************************************************************
  // Coding functions
  // ****************************************************************
  function automatic logic [4:0] fenp_enc(input logic [3:0] n);
    return ENC_TAB[5*int'(n) +: 5];
  endfunction : fenp_enc

  // Returns {valid, nibble}
  function automatic logic [4:0] fenp_dec(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TAB[5*i +: 5] == c) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : fenp_dec

  // Returns {is_violation, error report nibble}
  function automatic logic [4:0] fenp_viol(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 10; i++) begin
      if (VIOL_TAB[5*i +: 5] == c) begin
        if (i == 0) begin
          r = {1'b1, NIB_V0};
        end else if (i == 1) begin
          r = {1'b1, NIB_V1};
        end else begin
          r = {1'b1, 4'(NIB_V2 + 4'(i - 2))};
        end
      end
    end
    return r;
  endfunction : fenp_viol

  // Two zeros at least two bit positions apart
  function automatic logic fenp_split0(input logic [9:0] w);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 10; i++) begin
      for (int j = i + 2; j < 10; j++) begin
        if (!w[i] && !w[j]) begin
          r = 1'b1;
        end
      end
    end
    return r;
  endfunction : fenp_split0

endpackage : fenp_pkg

// file: logic/fenp_pcs.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: MII data moves as 4-bit nibbles on a nominal 25 MHz clock.
// R2: Each transmit nibble maps to its fixed 5-bit data code group.
// R3: A valid received data group yields its nibble with valid high.
// R4: Rising transmit enable inserts J then K; data never makes controls.
// R5: Frame end emits T then R.
// R6: Idle groups go out between frames; received idle keeps valid low.
// R7: Control or H group inside frame data gives error and nibble 0000.
// R8: Invalid group gives error, nibble 5h or 6h by select bit.
// R9: Error report mode gives each invalid group its own nibble.
// R10: Carrier on transmit, or two split zeros in ten received bits.
// R11: Carrier holds until transmit idle and ten received ones.
// R12: Carrier may change at any instant; the controller synchronises it.
// R13: Link is stable after valid levels for at least 1 ms.
// R14: Levels low over 350 us drop link, flag change, count it.
// R15: With negotiation on, also need 100 Mb/s and 12 idle groups.
// R16: Half duplex collision when receive and transmit overlap.
// R17: Carrier without a J then K start is a false carrier.
// R18: False carrier gives error and 1110 until two idle groups.
// R19: Each false carrier event increments the counter at 13h.
// R20: Repeater or full duplex makes carrier follow receive only.
// R21: One group per nibble, one nibble per group, fixed latency.
module fenp_pcs #(
  parameter int LINK_UP_CYCLES   = fenp_pkg::LINK_UP_CYC,
  parameter int LINK_DOWN_CYCLES = fenp_pkg::LINK_DOWN_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       mii_clk,
  input  wire logic       tx_en,
  input  wire logic [3:0] txd,
  input  wire logic [4:0] rx_code,
  input  wire logic       sig_ok,
  input  wire logic       repeater,
  input  wire logic       full_duplex,
  input  wire logic       an_enable,
  input  wire logic       speed100,
  input  wire logic       err_report,
  input  wire logic       code_err_sel,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_rd,
  output logic      [4:0] tx_code,
  output logic      [3:0] rxd,
  output logic            rx_dv,
  output logic            rx_er,
  output logic            crs,
  output logic            col,
  output logic            link_up,
  output logic            link_chg,
  output logic     [15:0] reg_rdata,
  output logic            reg_valid
);
  import fenp_pkg::*;

  localparam int UW = $clog2(LINK_UP_CYCLES + 1);
  localparam int DW = $clog2(LINK_DOWN_CYCLES + 1);

  // ****************************************************************
  // Link domain reset and pin synchronisers
  // ****************************************************************
  logic       lrst_m_r;
  logic       lrst_r;
  logic [3:0] lcfg_m_r;
  logic [3:0] lcfg_r;
  logic       rx_only;

  always_ff @(posedge mii_clk) begin
    lrst_m_r <= reset;
    lrst_r   <= lrst_m_r;
  end

  always_ff @(posedge mii_clk) begin
    lcfg_m_r <= {repeater, full_duplex, err_report, code_err_sel};
    lcfg_r   <= lcfg_m_r;
  end

  assign rx_only = lcfg_r[3] | lcfg_r[2];

  // ****************************************************************
  // Transmit encoder
  // ****************************************************************
  // Two nibbles of delay make room for J and K ahead of the data
  logic [3:0] ten_r;
  logic [3:0] tn1_r;
  logic [3:0] tn2_r;
  logic [4:0] tx_code_r;
  logic [4:0] tx_code_nxt;
  logic       tx_act;

  always_ff @(posedge mii_clk) begin
    if (lrst_r) begin
      ten_r <= 4'h0;
      tn1_r <= 4'h0;
      tn2_r <= 4'h0;
    end else begin
      ten_r <= {ten_r[2:0], tx_en};
      tn1_r <= txd;                                         // [R1]
      tn2_r <= tn1_r;
    end
  end

  always_comb begin
    if (tx_en && !ten_r[0]) begin
      tx_code_nxt = C_J;                                    // [R4]
    end else if (ten_r[0] && !ten_r[1]) begin
      tx_code_nxt = C_K;                                    // [R4]
    end else if (ten_r[1]) begin
      tx_code_nxt = fenp_enc(tn2_r);                        // [R2] [R21]
    end else if (ten_r[2]) begin
      tx_code_nxt = C_T;                                    // [R5]
    end else if (ten_r[3]) begin
      tx_code_nxt = C_R;                                    // [R5]
    end else begin
      tx_code_nxt = C_I;                                    // [R6]
    end
  end

  always_ff @(posedge mii_clk) begin
    if (lrst_r) begin
      tx_code_r <= C_I;
    end else begin
      tx_code_r <= tx_code_nxt;
    end
  end

  assign tx_act  = tx_en | (|ten_r);
  assign tx_code = tx_code_r;

  // ****************************************************************
  // Receive carrier, collision and idle run
  // ****************************************************************
  logic [4:0] rprev_r;
  logic [9:0] rwin;
  logic       rdet;
  logic       rquiet;
  logic       rx_act_r;
  logic       rx_act_nxt;
  logic       crs_r;
  logic       col_r;
  logic [3:0] irun_r;
  logic       idle12_r;

  assign rwin   = {rprev_r, rx_code};
  assign rdet   = fenp_split0(rwin);
  assign rquiet = &rwin;

  always_comb begin
    if (rquiet) begin
      rx_act_nxt = 1'b0;                                    // [R11]
    end else if (rdet) begin
      rx_act_nxt = 1'b1;                                    // [R10]
    end else begin
      rx_act_nxt = rx_act_r;                                // [R11]
    end
  end

  always_ff @(posedge mii_clk) begin
    if (lrst_r) begin
      rprev_r  <= C_I;
      rx_act_r <= 1'b0;
      crs_r    <= 1'b0;
      col_r    <= 1'b0;
    end else begin
      rprev_r  <= rx_code;
      rx_act_r <= rx_act_nxt;
      // Registered on mii_clk like the receive path; the controller must sync it
      crs_r    <= rx_act_nxt | (tx_act & !rx_only);       // [R10] [R20] [R12]
      col_r    <= !lcfg_r[2] & tx_act & rx_act_nxt;         // [R16]
    end
  end

  always_ff @(posedge mii_clk) begin
    if (lrst_r) begin
      irun_r   <= 4'h0;
      idle12_r <= 1'b0;
    end else begin
      if (rx_code != C_I) begin
        irun_r <= 4'h0;
      end else if (irun_r != IDLE_RUN) begin
        irun_r <= irun_r + 4'h1;
      end
      idle12_r <= (rx_code == C_I) && (irun_r >= IDLE_RUN - 4'h1); // [R15]
    end
  end

  assign crs = crs_r;
  assign col = col_r;

  // ****************************************************************
  // Receive decoder
  // ****************************************************************
  fenp_rx_t   rx_st_r;
  fenp_rx_t   rx_st_nxt;
  logic [4:0] rdec;
  logic [4:0] rvio;
  logic [3:0] rxd_r;
  logic [3:0] rxd_nxt;
  logic       rx_dv_r;
  logic       rx_dv_nxt;
  logic       rx_er_r;
  logic       rx_er_nxt;
  logic       fc_ev;
  logic       fc_tgl_r;

  assign rdec = fenp_dec(rx_code);
  assign rvio = fenp_viol(rx_code);

  always_comb begin
    rx_st_nxt = rx_st_r;
    rxd_nxt   = NIB_CTL;
    rx_dv_nxt = 1'b0;
    rx_er_nxt = 1'b0;
    fc_ev     = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: begin
        if (rdet && !rx_act_r) begin
          if (rx_code == C_J) begin
            rx_st_nxt = RX_J;
          end else begin
            rx_st_nxt = RX_FALSE;                           // [R17]
            fc_ev     = 1'b1;
            rx_er_nxt = 1'b1;
            rxd_nxt   = NIB_FALSE;                          // [R18]
          end
        end
      end
      RX_J: begin
        if (rx_code == C_K) begin
          rx_st_nxt = RX_DATA;
        end else begin
          rx_st_nxt = RX_FALSE;                             // [R17]
          fc_ev     = 1'b1;
          rx_er_nxt = 1'b1;
          rxd_nxt   = NIB_FALSE;                            // [R18]
        end
      end
      RX_DATA: begin
        rx_dv_nxt = 1'b1;
        if (rx_code == C_T) begin
          rx_st_nxt = RX_END;
          rx_dv_nxt = 1'b0;
        end else if (rdec[4]) begin
          rxd_nxt   = rdec[3:0];                            // [R3] [R21]
        end else if (rvio[4]) begin
          rx_er_nxt = 1'b1;                                 // [R8]
          if (lcfg_r[1]) begin
            rxd_nxt = rvio[3:0];                            // [R9]
          end else begin
            rxd_nxt = lcfg_r[0] ? NIB_VIOL_S : NIB_VIOL_N;  // [R8]
          end
        end else begin
          rx_er_nxt = 1'b1;                                 // [R7]
          rxd_nxt   = NIB_CTL;
        end
        if (rquiet) begin
          rx_st_nxt = RX_IDLE;
        end
      end
      RX_END: begin
        if (rx_code == C_I) begin
          rx_st_nxt = RX_IDLE;                              // [R6]
        end
      end
      RX_FALSE: begin
        rx_er_nxt = 1'b1;
        rxd_nxt   = NIB_FALSE;                              // [R18]
        if (rx_code == C_I && rprev_r == C_I) begin
          rx_st_nxt = RX_IDLE;
          rx_er_nxt = 1'b0;
          rxd_nxt   = NIB_CTL;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge mii_clk) begin
    if (lrst_r) begin
      rx_st_r  <= RX_IDLE;
      rxd_r    <= NIB_CTL;
      rx_dv_r  <= 1'b0;
      rx_er_r  <= 1'b0;
      fc_tgl_r <= 1'b0;
    end else begin
      rx_st_r  <= rx_st_nxt;
      rxd_r    <= rxd_nxt;
      rx_dv_r  <= rx_dv_nxt;
      rx_er_r  <= rx_er_nxt;
      fc_tgl_r <= fc_tgl_r ^ fc_ev;                         // [R19]
    end
  end

  assign rxd   = rxd_r;
  assign rx_dv = rx_dv_r;
  assign rx_er = rx_er_r;

  // ****************************************************************
  // Link integrity and counters, system clock
  // ****************************************************************
  logic [3:0]    scfg_m_r;
  logic [3:0]    scfg_r;
  logic          fc_m_r;
  logic          fc_s_r;
  logic          fc_d_r;
  logic [UW-1:0] ok_cnt_r;
  logic [DW-1:0] low_cnt_r;
  logic          stable;
  logic          gone;
  logic          link_up_r;
  logic          link_chg_r;
  logic [15:0]   drop_cnt_r;
  logic [15:0]   fc_cnt_r;
  logic [15:0]   reg_rdata_r;
  logic          reg_valid_r;

  always_ff @(posedge clk) begin
    scfg_m_r <= {sig_ok, an_enable, speed100, idle12_r};
    scfg_r   <= scfg_m_r;
    fc_m_r   <= fc_tgl_r;
    fc_s_r   <= fc_m_r;
    fc_d_r   <= fc_s_r;
  end

  assign stable = ok_cnt_r == UW'(LINK_UP_CYCLES);
  assign gone   = low_cnt_r == DW'(LINK_DOWN_CYCLES);

  always_ff @(posedge clk) begin
    if (reset || !scfg_r[3]) begin
      ok_cnt_r <= '0;
    end else if (!stable) begin
      ok_cnt_r <= ok_cnt_r + UW'(1);                        // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (reset || scfg_r[3]) begin
      low_cnt_r <= '0;
    end else if (!gone) begin
      low_cnt_r <= low_cnt_r + DW'(1);                      // [R14]
    end
  end

  // Drop and raise are exclusive: stable needs levels, gone needs none
  always_ff @(posedge clk) begin
    if (reset) begin
      link_up_r  <= 1'b0;
      link_chg_r <= 1'b0;
      drop_cnt_r <= CNT_RST;
    end else begin
      link_chg_r <= link_up_r & gone;                       // [R14]
      if (gone) begin
        link_up_r <= 1'b0;                                  // [R14]
      end else if (stable && (!scfg_r[2] || (scfg_r[1] && scfg_r[0])))
      begin
        link_up_r <= 1'b1;                                  // [R13] [R15]
      end
      if (link_up_r && gone) begin
        drop_cnt_r <= drop_cnt_r + 16'h0001;                // [R14]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fc_cnt_r <= CNT_RST;
    end else if (fc_s_r ^ fc_d_r) begin
      fc_cnt_r <= fc_cnt_r + 16'h0001;                      // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_valid_r <= 1'b0;
      reg_rdata_r <= 16'h0000;
    end else begin
      reg_valid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= (reg_addr == ADDR_DROP) ? drop_cnt_r :
                       (reg_addr == ADDR_FC) ? fc_cnt_r : 16'h0000;
      end
    end
  end

  assign link_up   = link_up_r;
  assign link_chg  = link_chg_r;
  assign reg_rdata = reg_rdata_r;
  assign reg_valid = reg_valid_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_tx_start;
    !tx_en ##1 tx_en;
  endsequence
  sequence s_tx_end;
    tx_en ##1 !tx_en [*4];
  endsequence

  property p_tx_start;
    @(posedge mii_clk) disable iff (lrst_r)
      s_tx_start |=> tx_code == C_J ##1 tx_code == C_K;
  endproperty
  a_tx_start: assert property (p_tx_start)                  // [R4]
    else $error("start delimiter missing");

  property p_tx_data;
    @(posedge mii_clk) disable iff (lrst_r)
      tx_en |-> ##3 (tx_code == fenp_enc($past(txd, 3)));
  endproperty
  a_tx_data: assert property (p_tx_data)                    // [R2]
    else $error("wrong data code group");

  property p_tx_end;
    @(posedge mii_clk) disable iff (lrst_r)
      s_tx_end |-> tx_code == C_T ##1 tx_code == C_R;
  endproperty
  a_tx_end: assert property (p_tx_end)                      // [R5]
    else $error("end delimiter missing");

  property p_tx_idle;
    @(posedge mii_clk) disable iff (lrst_r)
      !tx_en [*6] |-> tx_code == C_I;
  endproperty
  a_tx_idle: assert property (p_tx_idle)                    // [R6]
    else $error("idle not sent between frames");

  property p_rx_data;
    @(posedge mii_clk) disable iff (lrst_r)
      rx_st_r == RX_DATA && rdec[4] |=>
        rx_dv && !rx_er && rxd == $past(rdec[3:0]);
  endproperty
  a_rx_data: assert property (p_rx_data)                    // [R3]
    else $error("valid data not presented");

  property p_rx_ctl;
    @(posedge mii_clk) disable iff (lrst_r)
      rx_st_r == RX_DATA && (rx_code == C_H || rx_code == C_J) |=>
        rx_er && rxd == NIB_CTL;
  endproperty
  a_rx_ctl: assert property (p_rx_ctl)                      // [R7]
    else $error("control in data not flagged");

  property p_rx_viol;
    @(posedge mii_clk) disable iff (lrst_r)
      rx_st_r == RX_DATA && rvio[4] && !lcfg_r[1] |=> rx_er &&
        rxd == ($past(lcfg_r[0]) ? NIB_VIOL_S : NIB_VIOL_N);
  endproperty
  a_rx_viol: assert property (p_rx_viol)                    // [R8]
    else $error("violation nibble wrong");

  property p_crs;
    @(posedge mii_clk) disable iff (lrst_r)
      rdet && !rquiet |=> crs;
  endproperty
  a_crs: assert property (p_crs)                            // [R10]
    else $error("carrier not raised");

  property p_col;
    @(posedge mii_clk) disable iff (lrst_r)
      col |-> !$past(lcfg_r[2]) && $past(tx_act);
  endproperty
  a_col: assert property (p_col)                            // [R16]
    else $error("collision without overlap");

  property p_false;
    @(posedge mii_clk) disable iff (lrst_r)
      rx_st_r == RX_J && rx_code != C_K |=>
        rx_er && rxd == NIB_FALSE && fc_tgl_r != $past(fc_tgl_r);
  endproperty
  a_false: assert property (p_false)                        // [R17]
    else $error("false carrier not flagged");

  property p_fc_cnt;
    @(posedge clk) disable iff (reset)
      fc_s_r != fc_d_r |=> fc_cnt_r == $past(fc_cnt_r) + 16'h0001;
  endproperty
  a_fc_cnt: assert property (p_fc_cnt)                      // [R19]
    else $error("false carrier count missed");

  property p_drop;
    @(posedge clk) disable iff (reset)
      link_up_r && gone |=> !link_up_r && link_chg_r &&
        drop_cnt_r == $past(drop_cnt_r) + 16'h0001;
  endproperty
  a_drop: assert property (p_drop)                          // [R14]
    else $error("link drop not handled");

  property p_up;
    @(posedge clk) disable iff (reset)
      $rose(link_up_r) |-> $past(stable) && $past(scfg_r[3]);
  endproperty
  a_up: assert property (p_up)                              // [R13]
    else $error("link raised before stable");

endmodule : fenp_pcs

// file: bench/fenp_mac.sv
`timescale 1ns/10ps
module fenp_mac (
  input  wire logic       mii_clk,
  input  wire logic       crs,
  output logic            tx_en,
  output logic      [3:0] txd,
  output logic            crs_s
);
  logic [1:0] crs_ff;

  initial begin
    tx_en = 1'b0;
    txd   = 4'h0;
  end

  // Carrier sense may move at any instant, so it passes two flops
  always_ff @(posedge mii_clk) begin
    crs_ff <= {crs_ff[0], crs};
  end
  assign crs_s = crs_ff[1];

  // Outside a frame txd toggles so a stray sample of it cannot pass
  always @(posedge mii_clk) begin
    if (!tx_en) txd <= ~txd;
  end

  // One nibble per clock, changed just after the edge
  task automatic send(input logic [3:0] d[$]);
    foreach (d[k]) begin
      @(posedge mii_clk);
      #1;
      tx_en = 1'b1;
      txd   = d[k];
    end
    @(posedge mii_clk);
    #1;
    tx_en = 1'b0;
  endtask : send
endmodule : fenp_mac

// file: bench/tb_fast_ethernet_nibble_pcs.sv
`timescale 1ns/10ps
module tb_fast_ethernet_nibble_pcs;
  import fenp_pkg::*;
  // ****************************************************************
  // Clocks and design
  // ****************************************************************
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
    5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
    5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [4:0] VC [10] = '{5'h00, 5'h01, 5'h02, 5'h03,
    5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};
  logic        clk, reset, mii_clk, tx_en, sig_ok, repeater, full_duplex;
  logic        an_enable, speed100, err_report, code_err_sel, reg_rd;
  logic        rx_dv, rx_er, crs, col, link_up, link_chg, reg_valid, crs_s;
  logic  [3:0] txd, rxd;
  logic  [4:0] rx_code, reg_addr, tx_code;
  logic [15:0] reg_rdata;
  int          fails, n_compared;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    mii_clk = 1'b0;
    #3.7;
    forever #80 mii_clk = ~mii_clk;
  end

  fenp_pcs #(.LINK_UP_CYCLES(40), .LINK_DOWN_CYCLES(20)) u_dut (
    .clk(clk), .reset(reset), .mii_clk(mii_clk), .tx_en(tx_en),
    .txd(txd), .rx_code(rx_code), .sig_ok(sig_ok), .repeater(repeater),
    .full_duplex(full_duplex), .an_enable(an_enable),
    .speed100(speed100), .err_report(err_report),
    .code_err_sel(code_err_sel), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .tx_code(tx_code), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .crs(crs), .col(col), .link_up(link_up), .link_chg(link_chg),
    .reg_rdata(reg_rdata), .reg_valid(reg_valid));

  fenp_mac u_mac (.mii_clk(mii_clk), .crs(crs), .tx_en(tx_en),
    .txd(txd), .crs_s(crs_s));

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  // Nibble is only meaningful while valid or error is up
  task automatic rx_step(input logic [4:0] c, input logic on,
                         input logic dv, input logic er,
                         input logic [3:0] d);
    rx_code = c;
    @(posedge mii_clk);
    #1;
    if (on) begin
      chk1(rx_dv, dv);
      chk1(rx_er, er);
      if (dv || er) chk({12'h000, rxd}, {12'h000, d});
    end
  endtask : rx_step

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk1(reg_valid, 1'b1);
    chk(reg_rdata, exp);
  endtask : rd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_tx;
    logic [4:0] exp[$];
    exp = '{C_J, C_K, ENC[0], ENC[1], ENC[15], ENC[10], C_T, C_R, C_I};
    fork
      u_mac.send('{4'h0, 4'h1, 4'hF, 4'hA});
      begin
        rx_step(C_J, 0, 0, 0, 0);
        rx_step(C_K, 0, 0, 0, 0);
        repeat (4) rx_step(ENC[5], 0, 0, 0, 0);
        rx_step(C_T, 0, 0, 0, 0);
        rx_step(C_R, 0, 0, 0, 0);
        repeat (3) rx_step(C_I, 0, 0, 0, 0);
      end
      begin
        for (int i = 0; i < 8 && tx_code === C_I; i++) @(posedge mii_clk) #2;
        foreach (exp[i]) begin
          chk({11'h000, tx_code}, {11'h000, exp[i]});
          if (i == 3) chk1(col, 1'b1);
          if (i == 3) chk1(crs, 1'b1);
          if (i == 5) chk1(crs_s, 1'b1);
          @(posedge mii_clk) #2;
        end
      end
    join
    repeat (6) @(posedge mii_clk) #1;
    chk1(crs, 1'b0);
    $display("test tx done");
  endtask : t_tx

  task automatic t_rx(input logic rep, input logic sel);
    logic [3:0] e;
    err_report   = rep;
    code_err_sel = sel;
    repeat (4) @(posedge mii_clk) #1;
    rx_step(C_I, 0, 0, 0, 0);
    rx_step(C_J, 1, 0, 0, 0);
    rx_step(C_K, 1, 0, 0, 0);
    rx_step(ENC[3], 1, 1, 0, 4'h3);
    rx_step(C_H, 1, 1, 1, 4'h0);
    rx_step(C_R, 1, 1, 1, 4'h0);
    chk1(crs, 1'b1);
    for (int i = 0; i < 10; i++) begin
      e = rep ? (i == 0 ? 4'h1 : i == 1 ? 4'h7 : 4'(6 + i))
              : (sel ? 4'h6 : 4'h5);
      rx_step(VC[i], 1, 1, 1, e);
    end
    rx_step(C_T, 1, 0, 0, 0);
    rx_step(C_R, 1, 0, 0, 0);
    repeat (3) rx_step(C_I, 1, 0, 0, 0);
    chk1(crs, 1'b0);
    $display("test rx done");
  endtask : t_rx

  task automatic t_false;
    rx_step(C_I, 0, 0, 0, 0);
    rx_step(5'h0E, 1, 0, 1, 4'hE);
    rx_step(ENC[10], 0, 0, 0, 0);
    rx_step(ENC[10], 0, 0, 0, 0);
    chk1(rx_er, 1'b1);
    chk({12'h000, rxd}, 16'h000E);
    // One idle group is not enough to leave the false carrier state
    rx_step(C_I, 1, 0, 1, 4'hE);
    rx_step(C_I, 1, 0, 0, 0);
    // J followed by something other than K
    rx_step(C_J, 1, 0, 0, 0);
    rx_step(ENC[10], 1, 0, 1, 4'hE);
    repeat (2) rx_step(C_I, 0, 0, 0, 0);
    rx_step(C_I, 1, 0, 0, 0);
    rd(5'h13, 16'h0002);
    $display("test false carrier done");
  endtask : t_false

  task automatic t_rep;
    // Pass 0 repeater select, pass 1 full duplex
    for (int m = 0; m < 2; m++) begin
      repeater    = (m == 0);
      full_duplex = (m == 1);
      repeat (4) @(posedge mii_clk) #1;
      fork
        u_mac.send('{4'h1, 4'h2});
        repeat (6) @(posedge mii_clk) #1 chk1(crs, 1'b0);
      join
    end
    repeater    = 1'b0;
    full_duplex = 1'b0;
    $display("test repeater done");
  endtask : t_rep

  task automatic t_link;
    @(posedge clk) #1;
    sig_ok = 1'b1;
    repeat (38) @(posedge clk) #1;
    chk1(link_up, 1'b0);
    for (int i = 0; i < 20 && link_up !== 1'b1; i++) @(posedge clk) #1;
    chk1(link_up, 1'b1);
    sig_ok = 1'b0;
    repeat (15) @(posedge clk) #1;
    chk1(link_up, 1'b1);
    for (int i = 0; i < 30 && link_chg !== 1'b1; i++) @(posedge clk) #1;
    chk1(link_chg, 1'b1);
    chk1(link_up, 1'b0);
    rd(5'h12, 16'h0001);
    rd(5'h05, 16'h0000);
    an_enable = 1'b1;
    sig_ok    = 1'b1;
    repeat (100) @(posedge clk) #1;
    chk1(link_up, 1'b0);
    speed100 = 1'b1;
    for (int i = 0; i < 400 && link_up !== 1'b1; i++) @(posedge clk) #1;
    chk1(link_up, 1'b1);
    $display("test link done");
  endtask : t_link

  // ****************************************************************
  // Run
  // ****************************************************************
  task automatic wrap_up;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    reset        = 1'b1;
    sig_ok       = 1'b0;
    repeater     = 1'b0;
    full_duplex  = 1'b0;
    an_enable    = 1'b0;
    speed100     = 1'b0;
    err_report   = 1'b0;
    code_err_sel = 1'b0;
    reg_addr     = 5'h00;
    reg_rd       = 1'b0;
    rx_code      = C_I;
    // Reset must span three link clock edges, so it is counted there
    repeat (6) @(posedge mii_clk);
    @(posedge clk) #1 reset = 1'b0;
    repeat (4) @(posedge mii_clk) #1;
    t_tx;
    t_rx(1'b0, 1'b0);
    t_rx(1'b0, 1'b1);
    t_rx(1'b1, 1'b0);
    t_false;
    t_rep;
    t_link;
    wrap_up;
  end

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule : tb_fast_ethernet_nibble_pcs
